// ---- src/dual_timer_pkg.sv ----
// Package: register map, field positions, reset values and codes of the dual timer
package dual_timer_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] short_timer_control_off = 8'h00;
  localparam logic [7:0] shared_timer_control_off = 8'h04;
  localparam logic [7:0] long_timer_control_off = 8'h08;
  localparam logic [7:0] short_reload_high_off = 8'h0C;
  localparam logic [7:0] short_reload_low_off = 8'h10;
  localparam logic [7:0] long_reload_high_off = 8'h14;
  localparam logic [7:0] long_reload_low_off = 8'h18;
  localparam logic [7:0] capture_high_off = 8'h1C;
  localparam logic [7:0] capture_low_off = 8'h20;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int enable_bit = 7;
  localparam int single_pass_bit = 6;
  localparam int status_bit = 5;
  localparam int capture_ie_bit = 2;
  localparam int count_ie_bit = 1;
  localparam int demod_mode_bit = 7;
  localparam int edge_sel_msb = 5;
  localparam int edge_sel_lsb = 4;
  localparam int pp_mode_msb = 3;
  localparam int pp_mode_lsb = 2;
  localparam int short_init_bit = 1;
  localparam int long_init_bit = 0;
  localparam int fall_flag_bit = 1;
  localparam int rise_flag_bit = 0;

  // ************************************************************
  // Codes and reset values
  // ************************************************************
  localparam logic [1:0] edge_none = 2'h0;
  localparam logic [1:0] edge_rise = 2'h1;
  localparam logic [1:0] edge_fall = 2'h2;
  localparam logic [1:0] edge_both = 2'h3;
  localparam logic [1:0] pp_mode_off = 2'h0;
  localparam logic [1:0] pp_mode_on = 2'h1;
  localparam logic [7:0] reload_reset = 8'h00;
  localparam logic [15:0] long_full = 16'hFFFF;
  localparam logic [15:0] long_one = 16'h0001;
  localparam logic [7:0] short_one = 8'h01;
  localparam logic [31:0] rdata_reset = 32'h0000_0000;

  typedef enum logic [2:0] {
    pp_idle = 3'b001,
    pp_short = 3'b010,
    pp_long = 3'b100
  } pp_state_type;

endpackage : dual_timer_pkg

// ---- src/edge_event_if.sv ----
// Interface: synchronised carrier edge events between detector and timer core
`timescale 1ns/10ps
interface edge_event_if;
  logic rise;
  logic fall;
  modport detector (output rise, output fall);
  modport consumer (input rise, input fall);
endinterface : edge_event_if

// ---- src/carrier_edge_detect.sv ----
// Carrier input synchroniser and one-pulse edge detector
`timescale 1ns/10ps
module carrier_edge_detect (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic carrier_in,
  edge_event_if.detector ev
);

  logic sync_first;
  logic sync_second;
  logic sync_last;
  logic rise_pulse;
  logic fall_pulse;

  // Two flops against metastability; only the second one is looked at [R20]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_first <= 1'b0;
      sync_second <= 1'b0;
      sync_last <= 1'b0;
    end else begin
      sync_first <= carrier_in;
      sync_second <= sync_first;
      sync_last <= sync_second;
    end
  end

  // One pulse per edge, so each edge is counted once [R20]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_pulse <= 1'b0;
      fall_pulse <= 1'b0;
    end else begin
      rise_pulse <= sync_second & ~sync_last;
      fall_pulse <= ~sync_second & sync_last;
    end
  end

  assign ev.rise = rise_pulse;
  assign ev.fall = fall_pulse;

endmodule : carrier_edge_detect

// ---- src/dual_timer_demod_pingpong.sv ----
// Top: short and long timers with demodulation capture, ping-pong and AHB-Lite slave
//
// Contract
// R1 - Software never loads long start count one
// R2 - Start count zero wraps silently to FFFF
// R3 - Software avoids reload writes during transfer
// R4 - Software sets long reloads to ones first
// R5 - First qualifying edge captures, reloads, starts
// R6 - Later edges capture complement, restart FFFF
// R7 - Capture sets edge flag, optional interrupt
// R8 - Single-pass demod ignores edges after first
// R9 - Short timeout captures long count, no reload
// R10 - Single-pass rewrite zero-one rearms edge capture
// R11 - Demod zero wraps, sets timeout, interrupts
// R12 - Ping-pong only transmit, single-pass, mode bits; pp_active checks transmit and mode bits only, not single-pass
// R13 - Ping-pong begins with whichever timer enabled
// R14 - Short start drives initial level, picks reload
// R15 - Short terminal count hands over to long
// R16 - Long terminal count hands back to short
// R17 - Terminal count interrupts gated per timer
// R18 - Mode bits zero end ping-pong
// R19 - Software stops timers, clears flags first
// R20 - Carrier input synchronised before edge detection
// R21 - Flags sticky; interrupt is event AND enable
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module dual_timer_demod_pingpong (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic carrier_in,
  output logic short_timer_output,
  output logic long_timer_output,
  output logic short_irq,
  output logic long_irq,
  output logic capture_irq
);

  // ************************************************************
  // State
  // ************************************************************
  logic wr_pend;
  logic [7:0] wr_addr;
  logic short_en, short_sp, short_flag, short_ie;
  logic demod_mode, short_init, long_init;
  logic [1:0] edge_sel, pp_mode, edge_flag;
  logic long_en, long_sp, long_flag, capture_ie, count_ie;
  logic [7:0] short_reload_high, short_reload_low;
  logic [7:0] long_reload_high, long_reload_low;
  logic [7:0] capture_high, capture_low;
  logic [7:0] short_count;
  logic [15:0] long_count;
  logic long_wait;
  dual_timer_pkg::pp_state_type pp_state;

  edge_event_if ev ();

  carrier_edge_detect edge_unit (
    .hclk(hclk),
    .hresetn(hresetn),
    .carrier_in(carrier_in),
    .ev(ev.detector)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic write_hit(input logic pend, input logic [7:0] a,
                                     input logic [7:0] off);
    write_hit = pend && (a == off);
  endfunction : write_hit

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h00_0000, b};
  endfunction : byte_word

  // ************************************************************
  // Events
  // ************************************************************
  logic wr_short_timer_control, wr_shared_timer_control, wr_long_timer_control;
  logic short_tc, long_tc_tx, pp_active, pp_to_long, pp_to_short;
  logic short_start, long_start, demod_active, qual_edge, cap_first, cap_next;
  logic cap_edge, sp_capture, demod_zero, rearm;

  assign wr_short_timer_control = write_hit(wr_pend, wr_addr, dual_timer_pkg::short_timer_control_off);
  assign wr_shared_timer_control = write_hit(wr_pend, wr_addr, dual_timer_pkg::shared_timer_control_off);
  assign wr_long_timer_control = write_hit(wr_pend, wr_addr, dual_timer_pkg::long_timer_control_off);

  // Terminal count on the 1 to 0 step, so a start of 0 wraps unflagged [R2]
  assign short_tc = short_en && (short_count == dual_timer_pkg::short_one);
  assign long_tc_tx = !demod_mode && long_en && (long_count == dual_timer_pkg::long_one);

  // Ping-pong runs only in transmit mode with the mode code set [R12] [R18]
  assign pp_active = (pp_mode == dual_timer_pkg::pp_mode_on) && !demod_mode;
  assign pp_to_long = pp_active && short_tc && (pp_state == dual_timer_pkg::pp_short); // [R15]
  assign pp_to_short = pp_active && long_tc_tx && (pp_state == dual_timer_pkg::pp_long); // [R16]

  // A software enable starts whichever timer it names [R13]
  assign short_start = (wr_short_timer_control && hwdata[dual_timer_pkg::enable_bit] && !short_en)
                       || pp_to_short;
  assign long_start = (wr_long_timer_control && hwdata[dual_timer_pkg::enable_bit] && !long_en)
                      || pp_to_long;

  // Edge qualifier from the shared control edge select [R5]
  always_comb begin
    qual_edge = 1'b0;
    case (edge_sel)
      dual_timer_pkg::edge_rise: qual_edge = ev.rise;
      dual_timer_pkg::edge_fall: qual_edge = ev.fall;
      dual_timer_pkg::edge_both: qual_edge = ev.rise | ev.fall;
      default: qual_edge = 1'b0;
    endcase
  end

  assign demod_active = demod_mode && long_en && !long_start;
  assign cap_first = demod_active && qual_edge && long_wait; // [R5] [R10]
  assign cap_next = demod_active && qual_edge && !long_wait && !long_sp; // [R6] [R8]
  assign cap_edge = cap_first || cap_next;
  assign sp_capture = demod_active && long_sp && !long_wait && short_tc; // [R9]
  assign demod_zero = demod_active && !long_wait && !cap_edge && (long_count == 16'h0000);
  // Writing single-pass from 0 to 1 rearms a single capture [R10]
  assign rearm = wr_long_timer_control && demod_mode && !long_sp && hwdata[dual_timer_pkg::single_pass_bit];

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Zero wait state and always OKAY; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= dual_timer_pkg::rdata_reset;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hsel && hready && htrans[1] && !hwrite) begin
        if (haddr[7:0] == dual_timer_pkg::short_timer_control_off) begin
          hrdata <= byte_word({short_en, short_sp, short_flag, 3'h0, short_ie, 1'b0});
        end else if (haddr[7:0] == dual_timer_pkg::shared_timer_control_off) begin
          // In demod mode the low two bits show the edge flags instead of levels
          hrdata <= byte_word({demod_mode, 1'b0, edge_sel, pp_mode,
                               demod_mode ? edge_flag : {short_init, long_init}});
        end else if (haddr[7:0] == dual_timer_pkg::long_timer_control_off) begin
          hrdata <= byte_word({long_en, long_sp, long_flag, 2'h0, capture_ie, count_ie, 1'b0});
        end else if (haddr[7:0] == dual_timer_pkg::short_reload_high_off) begin
          hrdata <= byte_word(short_reload_high);
        end else if (haddr[7:0] == dual_timer_pkg::short_reload_low_off) begin
          hrdata <= byte_word(short_reload_low);
        end else if (haddr[7:0] == dual_timer_pkg::long_reload_high_off) begin
          hrdata <= byte_word(long_reload_high);
        end else if (haddr[7:0] == dual_timer_pkg::long_reload_low_off) begin
          hrdata <= byte_word(long_reload_low);
        end else if (haddr[7:0] == dual_timer_pkg::capture_high_off) begin
          hrdata <= byte_word(capture_high);
        end else if (haddr[7:0] == dual_timer_pkg::capture_low_off) begin
          hrdata <= byte_word(capture_low);
        end else begin
          hrdata <= dual_timer_pkg::rdata_reset;
        end
      end
    end
  end

  // ************************************************************
  // Reload registers
  // ************************************************************
  // Writes during a load are not guarded: software must avoid them [R3]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_reload_high <= dual_timer_pkg::reload_reset;
      short_reload_low <= dual_timer_pkg::reload_reset;
      long_reload_high <= dual_timer_pkg::reload_reset;
      long_reload_low <= dual_timer_pkg::reload_reset;
    end else begin
      if (write_hit(wr_pend, wr_addr, dual_timer_pkg::short_reload_high_off)) begin
        short_reload_high <= hwdata[7:0];
      end
      if (write_hit(wr_pend, wr_addr, dual_timer_pkg::short_reload_low_off)) begin
        short_reload_low <= hwdata[7:0];
      end
      if (write_hit(wr_pend, wr_addr, dual_timer_pkg::long_reload_high_off)) begin
        long_reload_high <= hwdata[7:0];
      end
      if (write_hit(wr_pend, wr_addr, dual_timer_pkg::long_reload_low_off)) begin
        long_reload_low <= hwdata[7:0];
      end
    end
  end

  // ************************************************************
  // Short timer control
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_en <= 1'b0;
      short_sp <= 1'b0;
      short_ie <= 1'b0;
      short_flag <= 1'b0;
    end else begin
      if (wr_short_timer_control) begin
        short_en <= hwdata[dual_timer_pkg::enable_bit];
        short_sp <= hwdata[dual_timer_pkg::single_pass_bit];
        short_ie <= hwdata[dual_timer_pkg::count_ie_bit];
        if (hwdata[dual_timer_pkg::status_bit]) begin
          short_flag <= 1'b0;
        end
      end
      // Hardware after software, so a hardware update beats a software write in the same cycle
      if (short_tc && (short_sp || pp_active)) begin
        short_en <= 1'b0; // [R15]
      end
      if (pp_to_short) begin
        short_en <= 1'b1; // [R16]
      end
      if (short_tc) begin
        short_flag <= 1'b1; // [R21]
      end
    end
  end

  // ************************************************************
  // Shared control
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      demod_mode <= 1'b0;
      edge_sel <= dual_timer_pkg::edge_none;
      pp_mode <= dual_timer_pkg::pp_mode_off;
      short_init <= 1'b0;
      long_init <= 1'b0;
      edge_flag <= 2'h0;
    end else begin
      if (wr_shared_timer_control) begin
        demod_mode <= hwdata[dual_timer_pkg::demod_mode_bit];
        edge_sel <= hwdata[dual_timer_pkg::edge_sel_msb:dual_timer_pkg::edge_sel_lsb];
        pp_mode <= hwdata[dual_timer_pkg::pp_mode_msb:dual_timer_pkg::pp_mode_lsb]; // [R18]
        if (demod_mode) begin
          edge_flag <= edge_flag & ~hwdata[1:0];
        end else begin
          short_init <= hwdata[dual_timer_pkg::short_init_bit];
          long_init <= hwdata[dual_timer_pkg::long_init_bit];
        end
      end
      // Flag names the edge that caused the capture [R7] [R21]
      if (cap_edge && ev.rise) begin
        edge_flag[dual_timer_pkg::rise_flag_bit] <= 1'b1;
      end
      if (cap_edge && ev.fall) begin
        edge_flag[dual_timer_pkg::fall_flag_bit] <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Long timer control
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      long_en <= 1'b0;
      long_sp <= 1'b0;
      long_flag <= 1'b0;
      capture_ie <= 1'b0;
      count_ie <= 1'b0;
    end else begin
      if (wr_long_timer_control) begin
        long_en <= hwdata[dual_timer_pkg::enable_bit];
        long_sp <= hwdata[dual_timer_pkg::single_pass_bit];
        capture_ie <= hwdata[dual_timer_pkg::capture_ie_bit];
        count_ie <= hwdata[dual_timer_pkg::count_ie_bit];
        if (hwdata[dual_timer_pkg::status_bit]) begin
          long_flag <= 1'b0;
        end
      end
      if (long_tc_tx && (long_sp || pp_active)) begin
        long_en <= 1'b0; // [R16]
      end
      if (pp_to_long) begin
        long_en <= 1'b1; // [R15]
      end
      if (long_tc_tx || demod_zero) begin
        long_flag <= 1'b1; // [R11] [R21]
      end
    end
  end

  // ************************************************************
  // Short counter and output
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_count <= 8'h00;
      short_timer_output <= 1'b0;
    end else begin
      if (short_start) begin
        // Initial level picks high or low reload [R14]
        short_timer_output <= short_init;
        short_count <= short_init ? short_reload_high : short_reload_low; // [R14]
      end else if (short_tc) begin
        short_timer_output <= ~short_timer_output;
        if (!short_sp && !pp_active) begin
          short_count <= short_timer_output ? short_reload_low : short_reload_high;
        end else begin
          short_count <= 8'h00;
        end
      end else if (short_en) begin
        short_count <= short_count - 8'h01;
      end
    end
  end

  // ************************************************************
  // Long counter, output and demod capture
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      long_count <= 16'h0000;
      long_timer_output <= 1'b0;
      long_wait <= 1'b0;
    end else begin
      if (long_start && demod_mode) begin
        long_wait <= 1'b1; // Counter holds until the first edge [R5]
      end else if (rearm) begin
        long_wait <= 1'b1; // [R10]
      end else if (cap_first) begin
        long_wait <= 1'b0;
      end
      if (long_start && !demod_mode) begin
        long_timer_output <= long_init; // [R15]
        long_count <= {long_reload_high, long_reload_low}; // [R15]
      end else if (long_start) begin
        long_count <= {long_reload_high, long_reload_low};
      end else if (cap_first) begin
        long_count <= {long_reload_high, long_reload_low}; // [R5]
      end else if (cap_next) begin
        long_count <= dual_timer_pkg::long_full; // [R6]
      end else if (long_tc_tx) begin
        long_timer_output <= ~long_timer_output;
        if (!long_sp && !pp_active) begin
          long_count <= {long_reload_high, long_reload_low};
        end else begin
          long_count <= 16'h0000;
        end
      end else if (long_en && !(demod_mode && long_wait)) begin
        // Zero steps to FFFF by wrap: silent in transmit, timeout in demod [R2] [R11]
        long_count <= long_count - 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_high <= 8'h00;
      capture_low <= 8'h00;
    end else begin
      if (cap_first || sp_capture) begin
        {capture_high, capture_low} <= long_count; // [R5] [R9]
      end else if (cap_next) begin
        {capture_high, capture_low} <= ~long_count; // [R6]
      end
    end
  end

  // ************************************************************
  // Ping-pong sequence
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pp_state <= dual_timer_pkg::pp_idle;
    end else begin
      case (pp_state)
        dual_timer_pkg::pp_idle: begin
          if (pp_active && short_start) begin
            pp_state <= dual_timer_pkg::pp_short; // [R13]
          end else if (pp_active && long_start) begin
            pp_state <= dual_timer_pkg::pp_long; // [R13]
          end
        end
        dual_timer_pkg::pp_short: begin
          if (!pp_active) begin
            pp_state <= dual_timer_pkg::pp_idle; // [R18]
          end else if (pp_to_long) begin
            pp_state <= dual_timer_pkg::pp_long;
          end
        end
        dual_timer_pkg::pp_long: begin
          if (!pp_active) begin
            pp_state <= dual_timer_pkg::pp_idle; // [R18]
          end else if (pp_to_short) begin
            pp_state <= dual_timer_pkg::pp_short;
          end
        end
        default: pp_state <= dual_timer_pkg::pp_idle;
      endcase
    end
  end

  // ************************************************************
  // Interrupt requests
  // ************************************************************
  // One-cycle pulses: event AND enable; no interrupt controller lives here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_irq <= 1'b0;
      long_irq <= 1'b0;
      capture_irq <= 1'b0;
    end else begin
      short_irq <= short_tc && short_ie; // [R17] [R21]
      long_irq <= (long_tc_tx || demod_zero) && count_ie; // [R11] [R17]
      capture_irq <= (cap_edge || sp_capture) && capture_ie; // [R7] [R9]
    end
  end

endmodule : dual_timer_demod_pingpong

// ---- tb/carrier_source.sv ----
// Partner: carrier source driving the demodulation input
`timescale 1ns/10ps
module carrier_source (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic level_req,
  output logic carrier_in
);
  // Level lands just after a rising hclk edge, registered on the same clock that samples it inside the block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carrier_in <= 1'b0;
    end else begin
      carrier_in <= level_req;
    end
  end
endmodule : carrier_source

// ---- tb/dual_timer_demod_pingpong_checker.sv ----
// Checker: port assertions of the dual timer
`timescale 1ns/10ps
module dual_timer_demod_pingpong_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic short_timer_output,
  input wire logic long_timer_output,
  input wire logic short_irq,
  input wire logic long_irq,
  input wire logic capture_irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_OKAY: assert property (hreadyout && !hresp) else $error("bus not ready");
  AST_RDATA_UPPER: assert property (hrdata[31:8] == 24'h0) else $error("upper bits");
  AST_RDATA_HOLD: assert property (!(hsel && hready && htrans[1] && !hwrite)
    |=> $stable(hrdata)) else $error("read data moved");
  AST_SHORT_PULSE: assert property (short_irq |=> !short_irq) else $error("short irq");
  AST_LONG_PULSE: assert property (long_irq |=> !long_irq) else $error("long irq");
  AST_CAPTURE_PULSE: assert property (capture_irq |=> !capture_irq) else $error("cap irq");
  AST_RESET_QUIET: assert property ($rose(hresetn) |-> !(short_irq || long_irq ||
    capture_irq || short_timer_output || long_timer_output)) else $error("busy at reset");
  AST_RESET_RDATA: assert property ($rose(hresetn) |-> hrdata == 32'h0) else $error("rdata");
endmodule : dual_timer_demod_pingpong_checker

// ---- tb/dual_timer_demod_pingpong_tb.sv ----
// Testbench: registers, demodulation capture and ping-pong of the dual timer
`timescale 1ns/10ps
module dual_timer_demod_pingpong_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic lvl = 1'b0;
  logic [31:0] rd;
  logic [31:0] hi;
  wire logic [31:0] rdata;
  wire logic rdy, carrier, s_out, l_out, s_irq, l_irq, c_irq;
  int n_errors = 0;
  int cmp_count = 0;
  int n_s, n_l, n_c, d, code, k;
  always #50 hclk = ~hclk;
  carrier_source src_u (.hclk(hclk), .hresetn(hresetn), .level_req(lvl), .carrier_in(carrier));
  dual_timer_demod_pingpong dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(rdy), .hreadyout(rdy), .hresp(), .hrdata(rdata), .carrier_in(carrier),
    .short_timer_output(s_out), .long_timer_output(l_out), .short_irq(s_irq),
    .long_irq(l_irq), .capture_irq(c_irq));
  // Counted mid-cycle so the main process never races the update
  always @(negedge hclk) begin
    if (!hresetn) begin
      {n_s, n_l, n_c} = 96'h0;
    end else begin
      n_s += int'(s_irq === 1'b1);
      n_l += int'(l_irq === 1'b1);
      n_c += int'(c_irq === 1'b1);
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (rdy !== 1'b1);
    rd = rdata;
  endtask : bus
  task automatic rst();
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : rst
  task automatic pulse(input int n);
    lvl <= 1'b1;
    repeat (4) @(posedge hclk);
    lvl <= 1'b0;
    repeat (n - 4) @(posedge hclk);
  endtask : pulse
  function automatic logic [31:0] exp_cap(input int k, input int code, input int d);
    if (k == 3) return 32'hFFFF;
    return (code == 3) ? 32'h3 : 32'(d - 1);
  endfunction : exp_cap
  task automatic report_and_stop();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hA02E));
    rst();
    // Every register and one unmapped word read back as zero
    for (k = 0; k < 10; k++) begin
      bus(1'b0, 8'(k * 4), 32'h0);
      check("reset value", rd, 32'h0);
    end
    bus(1'b1, dual_timer_pkg::capture_low_off, 32'h5A);
    bus(1'b0, dual_timer_pkg::capture_low_off, 32'h0);
    check("read-only capture", rd, 32'h0);
    d = $urandom_range(255);
    bus(1'b1, dual_timer_pkg::short_reload_low_off, 32'(d));
    bus(1'b0, dual_timer_pkg::short_reload_low_off, 32'h0);
    check("reload", rd, 32'(d));
    // Edge codes rise, fall, both, then single-pass on rising edges
    for (k = 0; k < 4; k++) begin
      code = (k == 3) ? 1 : k + 1;
      rst();
      bus(1'b1, dual_timer_pkg::long_reload_high_off, 32'hFF);
      bus(1'b1, dual_timer_pkg::long_reload_low_off, 32'hFF);
      bus(1'b1, dual_timer_pkg::shared_timer_control_off, 32'(8'h80 | code << 4));
      bus(1'b1, dual_timer_pkg::long_timer_control_off, (k == 3) ? 32'hC4 : 32'h84);
      d = $urandom_range(200, 20);
      pulse(8);
      pulse(d);
      pulse(8);
      repeat (10) @(posedge hclk);
      check("captures", n_c, (k == 3) ? 1 : ((code == 3) ? 6 : 3));
      bus(1'b0, dual_timer_pkg::capture_high_off, 32'h0);
      hi = rd;
      bus(1'b0, dual_timer_pkg::capture_low_off, 32'h0);
      check("capture", {16'h0, hi[7:0], rd[7:0]}, exp_cap(k, code, d));
      bus(1'b0, dual_timer_pkg::shared_timer_control_off, 32'h0);
      check("edge flags", rd, 32'(8'h80 | code << 4 | code));
    end
    // Single-pass rewritten zero then one takes exactly one more edge
    bus(1'b1, dual_timer_pkg::long_timer_control_off, 32'h84);
    bus(1'b1, dual_timer_pkg::long_timer_control_off, 32'hC4);
    pulse(8);
    pulse(8);
    repeat (10) @(posedge hclk);
    check("rearm", n_c, 32'h2);
    // Ping-pong: short starts high, so its high reload must be the one used
    rst();
    bus(1'b1, dual_timer_pkg::short_reload_high_off, 32'h6);
    bus(1'b1, dual_timer_pkg::short_reload_low_off, 32'h3C);
    bus(1'b1, dual_timer_pkg::long_reload_low_off, 32'($urandom_range(50, 10)));
    bus(1'b1, dual_timer_pkg::shared_timer_control_off, 32'h7);
    bus(1'b1, dual_timer_pkg::long_timer_control_off, 32'h42);
    bus(1'b1, dual_timer_pkg::short_timer_control_off, 32'hC2);
    @(negedge hclk);
    check("short level", {31'h0, s_out}, 32'h1);
    repeat (6) @(negedge hclk);
    check("long level", {31'h0, l_out}, 32'h1);
    repeat (14) @(posedge hclk);
    check("first pass", n_s, 32'h1);
    repeat (500) @(posedge hclk);
    check("alternation", 32'(n_s > 2 && n_l > 2 && (n_s - n_l) inside {0, 1}), 32'h1);
    bus(1'b1, dual_timer_pkg::shared_timer_control_off, 32'h0);
    repeat (200) @(posedge hclk);
    k = n_s + n_l;
    repeat (300) @(posedge hclk);
    check("stopped", n_s + n_l, k);
    report_and_stop();
  end
endmodule : dual_timer_demod_pingpong_tb
bind dual_timer_demod_pingpong dual_timer_demod_pingpong_checker chk_u (.hclk, .hresetn,
  .hsel, .hready, .htrans, .hwrite, .hreadyout, .hresp, .hrdata, .short_timer_output,
  .long_timer_output, .short_irq, .long_irq, .capture_irq);
